// >>> hpm_pkg.sv
// Package for the headphone mixer routing register block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package hpm_pkg;

	// Printed offsets are register indices; byte address is four times each.
	localparam logic [7:0] HPM_IDX_LSRC = 8'h64;
	localparam logic [7:0] HPM_IDX_RSRC = 8'h65;
	localparam logic [7:0] HPM_IDX_LGAIN = 8'h66;
	localparam logic [7:0] HPM_IDX_RGAIN = 8'h67;
	localparam int HPM_ADDR_W = 10;
	localparam logic [9:0] HPM_ADDR_LSRC = {HPM_IDX_LSRC, 2'b00};
	localparam logic [9:0] HPM_ADDR_RSRC = {HPM_IDX_RSRC, 2'b00};
	localparam logic [9:0] HPM_ADDR_LGAIN = {HPM_IDX_LGAIN, 2'b00};
	localparam logic [9:0] HPM_ADDR_RGAIN = {HPM_IDX_RGAIN, 2'b00};

	// Field positions.
	localparam int HPM_SEL_BIT = 7;
	localparam int HPM_MUTE_BIT = 8;
	localparam int HPM_LIN_ATT_BIT = 7;
	localparam int HPM_RIN_ATT_BIT = 6;
	localparam int HPM_LLINE_LSB = 3;
	localparam int HPM_RLINE_LSB = 0;

	// Writable bit masks and reset values, nine bits each.
	localparam logic [8:0] HPM_SRC_MASK = 9'h0BF;
	localparam logic [8:0] HPM_GAIN_MASK = 9'h1FF;
	localparam logic [8:0] HPM_SRC_RST = 9'h000;
	localparam logic [8:0] HPM_GAIN_RST = 9'h13F;

	localparam logic [1:0] HPM_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HPM_HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic ldac;
		logic rdac;
		logic linmix;
		logic rinmix;
		logic lline;
		logic rline;
	} hpm_src_s;

	typedef struct packed {
		logic silence;
		logic linmix_atten;
		logic rinmix_atten;
		logic [2:0] lline_gain;
		logic [2:0] rline_gain;
	} hpm_gain_s;

	typedef struct packed {
		logic [8:0] lsrc;
		logic [8:0] rsrc;
		logic [8:0] lgain;
		logic [8:0] rgain;
		logic wr_pend;
		logic [HPM_ADDR_W-1:0] addr;
		logic [31:0] rdata;
	} hpm_state_s;

endpackage

// >>> hpm_mixer_regs.sv
// Headphone mixer routing and gain registers on an AHB-Lite slave.
// Assumes one clock, hclk, and an asynchronous active-low reset.
//
// Notes on behaviour
// - Left source bits five to zero enable sources.
// - Right source bits five to zero likewise.
// - Any combination of sources may be enabled.
// - Left gain bit eight mutes, resets muted.
// - Right gain bit eight mutes, resets muted.
// - Left source bit seven selects mixer or DAC.
// - Right source bit seven selects mixer or DAC.
// - DAC paths have enable only, no gain.
// - Left gain bits seven, six: minus 6 dB.
// - Right gain bits seven, six: minus 6 dB.
// - Left line-in gain codes, reset 111.
// - Right line-in gain codes, reset 111.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns

module hpm_mixer_regs
	import hpm_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Routing controls.
	output hpm_src_s left_phones_mixer_src,
	output hpm_src_s right_phones_mixer_src,
	output logic left_volume_stage_source_sel,
	output logic right_volume_stage_source_sel,
	// Gain controls.
	output hpm_gain_s left_phones_mixer_gain,
	output hpm_gain_s right_phones_mixer_gain
);

	hpm_state_s st_r;
	hpm_state_s st_nxt;
	logic take;

	// Returns the masked register value shown at an address, zero if unmapped.
	function automatic logic [31:0] read_word(input hpm_state_s s,
		input logic [HPM_ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			HPM_ADDR_LSRC: v = {23'h0, s.lsrc & HPM_SRC_MASK};
			HPM_ADDR_RSRC: v = {23'h0, s.rsrc & HPM_SRC_MASK};
			HPM_ADDR_LGAIN: v = {23'h0, s.lgain};
			HPM_ADDR_RGAIN: v = {23'h0, s.rgain};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	assign take = hsel && hready && (htrans == HPM_HTRANS_NONSEQ);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.wr_pend = 1'b0;
		if (st_r.wr_pend)
		begin
			// Each source bit stores on its own, with no exclusivity.
			case (st_r.addr)
				HPM_ADDR_LSRC: st_nxt.lsrc = hwdata[8:0] & HPM_SRC_MASK;
				HPM_ADDR_RSRC: st_nxt.rsrc = hwdata[8:0] & HPM_SRC_MASK;
				HPM_ADDR_LGAIN: st_nxt.lgain = hwdata[8:0] & HPM_GAIN_MASK;
				HPM_ADDR_RGAIN: st_nxt.rgain = hwdata[8:0] & HPM_GAIN_MASK;
				default: st_nxt.lsrc = st_r.lsrc;
			endcase
		end
		if (take)
		begin
			st_nxt.addr = haddr[HPM_ADDR_W-1:0];
			st_nxt.wr_pend = hwrite;
			if (!hwrite)
			begin
				st_nxt.rdata = read_word(st_nxt, haddr[HPM_ADDR_W-1:0]);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r.lsrc <= HPM_SRC_RST;
			st_r.rsrc <= HPM_SRC_RST;
			st_r.lgain <= HPM_GAIN_RST;
			st_r.rgain <= HPM_GAIN_RST;
			st_r.wr_pend <= 1'b0;
			st_r.addr <= '0;
			st_r.rdata <= 32'h0000_0000;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_r.rdata;

	// DAC paths carry only their enable bits.
	assign left_phones_mixer_src = hpm_src_s'(st_r.lsrc[5:0]);
	assign right_phones_mixer_src = hpm_src_s'(st_r.rsrc[5:0]);
	assign left_volume_stage_source_sel = st_r.lsrc[HPM_SEL_BIT];
	assign right_volume_stage_source_sel = st_r.rsrc[HPM_SEL_BIT];
	assign left_phones_mixer_gain = hpm_gain_s'(st_r.lgain);
	assign right_phones_mixer_gain = hpm_gain_s'(st_r.rgain);

endmodule // hpm_mixer_regs

// >>> hpm_props.sv
// Checker for the mixer register block.
// Assumes a bind to hpm_mixer_regs.
`timescale 1ns/1ns
module hpm_props
	import hpm_pkg::*;
(
	input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr, hwdata, hrdata,
	input wire logic left_volume_stage_source_sel, right_volume_stage_source_sel,
	input wire hpm_src_s left_phones_mixer_src, right_phones_mixer_src,
	input wire hpm_gain_s left_phones_mixer_gain, right_phones_mixer_gain
);
	logic w_r, r_r;
	logic [9:0] a_r;
	logic [8:0] d_r;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) {w_r, r_r, a_r, d_r} <= '0;
		else
		begin
			w_r <= hsel && hready && htrans == HPM_HTRANS_NONSEQ && hwrite;
			r_r <= hsel && hready && htrans == HPM_HTRANS_NONSEQ && !hwrite;
			a_r <= haddr[9:0];
			d_r <= hwdata[8:0];
		end
	a_lsrc_write: assert property (w_r && a_r == HPM_ADDR_LSRC |=>
		{left_volume_stage_source_sel, left_phones_mixer_src} == {d_r[7], d_r[5:0]}) else $error("lsrc");
	a_rsrc_write: assert property (w_r && a_r == HPM_ADDR_RSRC |=>
		{right_volume_stage_source_sel, right_phones_mixer_src} == {d_r[7], d_r[5:0]}) else $error("rsrc");
	a_lgain_write: assert property (w_r && a_r == HPM_ADDR_LGAIN |=>
		left_phones_mixer_gain == d_r) else $error("lgain");
	a_rgain_write: assert property (w_r && a_r == HPM_ADDR_RGAIN |=>
		right_phones_mixer_gain == d_r) else $error("rgain");
	a_ctrl_hold: assert property (!w_r |=> $stable({left_phones_mixer_src, right_phones_mixer_src,
		left_volume_stage_source_sel, right_volume_stage_source_sel,
		left_phones_mixer_gain, right_phones_mixer_gain})) else $error("hold");
	a_lsrc_read: assert property (r_r && a_r == HPM_ADDR_LSRC |-> hrdata ==
		{24'h0, left_volume_stage_source_sel, 1'b0, left_phones_mixer_src}) else $error("lread");
	a_rgain_read: assert property (r_r && a_r == HPM_ADDR_RGAIN |->
		hrdata == {23'h0, right_phones_mixer_gain}) else $error("rread");
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus");
endmodule // hpm_props
bind hpm_mixer_regs hpm_props hpm_props_i (.*);

// >>> hpm_mixer_regs_tb.sv
// Testbench for the mixer register block.
// Assumes a zero-wait AHB-Lite slave.
`timescale 1ns/1ns
module hpm_mixer_regs_tb
	import hpm_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, ls, rs;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	hpm_src_s lsrc, rsrc;
	hpm_gain_s lg, rg;
	int mismatches = 0, num_checks = 0, cyc = 0;
	logic [31:0] adr [4] = '{HPM_ADDR_LSRC, HPM_ADDR_RSRC, HPM_ADDR_LGAIN, HPM_ADDR_RGAIN};
	logic [31:0] rst [4] = '{32'h0, 32'h0, 32'h13F, 32'h13F};
	logic [31:0] msk [4] = '{32'hBF, 32'hBF, 32'h1FF, 32'h1FF};
	hpm_mixer_regs hpm_mixer_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(HPM_HSIZE_WORD), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.left_phones_mixer_src(lsrc), .right_phones_mixer_src(rsrc),
		.left_volume_stage_source_sel(ls), .right_volume_stage_source_sel(rs),
		.left_phones_mixer_gain(lg), .right_phones_mixer_gain(rg));
	initial forever #4 hclk = ~hclk;
	always @(posedge hclk)
		if (++cyc > 3000)
		begin
			mismatches++;
			results();
		end
	task automatic check(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d);
		hsel <= 1; hwrite <= w; haddr <= a; htrans <= HPM_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		check({lg, rg, lsrc, rsrc, ls, rs}, {9'h13F, 9'h13F, 14'h0});
		foreach (adr[i])
		begin
			xfer(0, adr[i], 0);
			check(q, rst[i]);
			xfer(1, adr[i], 32'hFFFF_FFFF);
			xfer(0, adr[i], 0);
			check(q, msk[i]);
			xfer(1, adr[i], 32'h95 + i);
			xfer(0, adr[i], 0);
			check(q, (32'h95 + i) & msk[i]);
		end
		check({lg, rg, lsrc, rsrc, ls, rs}, {9'h097, 9'h098, 6'h15, 6'h16, 2'h3});
		xfer(1, 32'h1A0, 32'h1FF);
		xfer(0, 32'h1A0, 0);
		check(q, 32'h0);
		results();
	end
endmodule // hpm_mixer_regs_tb
